/* rtl/adc_cfg_pkg.sv */
// constants and carrier types for the remote adc configuration and port lock bank
// assumes one 100 MHz clock and a host front end that delivers decoded register accesses
package adc_cfg_pkg;

	localparam int          ADDR_W              = 16;
	localparam int          DATA_W              = 8;
	localparam logic [15:0] CHANNEL_CONFIG_ADDR = 16'hE708;
	localparam logic [15:0] PORT_LOCK_ADDR      = 16'hE7FE;

	localparam int          SELECT_LSB          = 0;
	localparam int          SELECT_W            = 4;
	localparam int          CLOCK_DISABLE_BIT   = 6;
	localparam int          SOFT_RESET_BIT      = 7;
	localparam int          PORT_LOCK_BIT       = 0;

	localparam logic [7:0]  CHANNEL_CONFIG_RST  = 8'h0F;
	localparam logic [7:0]  CHANNEL_CONFIG_MASK = 8'hCF;
	localparam logic [7:0]  PORT_LOCK_RST       = 8'h00;

	localparam int          PORT_SWITCH_TOGGLES = 3;
	localparam int          CLK_HALF_PERIOD     = 2;

	typedef struct packed {
		logic                  wr_en;
		logic                  rd_en;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
	} reg_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] channel_config;
		logic              port_locked;
		logic              spi_active;
		logic [1:0]        toggle_count;
		logic [1:0]        pin_sync;
		logic              pin_prev;
		logic              soft_reset_pulse;
		logic [DATA_W-1:0] rdata;
	} bank_state_t;

endpackage : adc_cfg_pkg

/* rtl/remote_clock_gen.sv */
// clock output toward the remote adcs, divided from the system clock
// assumes the disable level comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module remote_clock_gen #(
	parameter int HALF_PERIOD = adc_cfg_pkg::CLK_HALF_PERIOD
) (
	// system
	input  wire logic clk,
	input  wire logic reset,
	// control
	input  wire logic disable_clock,
	// pin
	output logic      remote_clock_output_pin
);

	typedef struct packed {
		logic [7:0] count;
		logic       level;
	} div_state_t;

	div_state_t state_q;
	div_state_t state_d;

	always_comb begin
		state_d = state_q;
		if (disable_clock) begin
			state_d.count = 8'h00;
			state_d.level = 1'b1; // R04
		end else if (state_q.count == 8'(HALF_PERIOD - 1)) begin
			state_d.count = 8'h00;
			state_d.level = ~state_q.level;
		end else begin
			state_d.count = state_q.count + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= '{count: 8'h00, level: 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	assign remote_clock_output_pin = state_q.level;

endmodule : remote_clock_gen

`default_nettype wire

/* rtl/adc_config_bank.sv */
// remote adc channel configuration register and host serial port lock register
// assumes the serial front end hands decoded byte accesses on clk; select pin is asynchronous
`timescale 1ns/1ps
`default_nettype none

// Contract
// R01: bits 0..3 select second voltage input per phase; reset value 1.
// R02: a cleared select routes that phase's temperature sensor to the second channel.
// R03: host clears select even on variants without a second input.
// R04: bit 6 set stops the remote clock output and holds it high.
// R05: writing 1 to bit 7 starts a soft reset of all remote adcs.
// R06: reserved bits reset to 0, read 0, and control nothing.
// R07: unlocked, three toggles of the select pin switch from i2c to spi.
// R08: a host on i2c writes 1 to the lock bit.
// R09: once i2c is locked, select pin toggles are ignored.
// R10: on spi, any write to the lock register locks spi in.
// R11: soft reset of the chipset keeps the port lock and choice.
// R12: hardware reset unlocks and makes i2c active.
module adc_config_bank (
	// system
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        chipset_soft_reset,
	// register access from the serial front end
	input  wire adc_cfg_pkg::reg_req_t       req,
	output logic [adc_cfg_pkg::DATA_W-1:0]   rdata,
	output logic                             rvalid,
	// host port pins
	input  wire logic                        select_or_stream_active_pin,
	output logic                             spi_port_active,
	output logic                             port_locked,
	// remote adc controls
	output logic                             phase_a_second_input_select,
	output logic                             phase_b_second_input_select,
	output logic                             phase_c_second_input_select,
	output logic                             neutral_second_input_select,
	output logic [3:0]                       temperature_route,
	output logic                             remote_adc_soft_reset,
	output logic                             remote_clock_output_pin
);

	adc_cfg_pkg::bank_state_t state_q;
	adc_cfg_pkg::bank_state_t state_d;
	logic                     rvalid_q;

	function automatic logic hit(input adc_cfg_pkg::reg_req_t r, input logic [15:0] a);
		hit = (r.addr == a);
	endfunction : hit

	logic cfg_write;
	logic lock_write;
	logic pin_edge;

	assign cfg_write  = req.wr_en && hit(req, adc_cfg_pkg::CHANNEL_CONFIG_ADDR);
	assign lock_write = req.wr_en && hit(req, adc_cfg_pkg::PORT_LOCK_ADDR);
	// second flop against the history flop only
	assign pin_edge   = state_q.pin_sync[1] ^ state_q.pin_prev;

	always_comb begin
		state_d = state_q;
		state_d.pin_sync = {state_q.pin_sync[0], select_or_stream_active_pin};
		state_d.pin_prev = state_q.pin_sync[1];
		state_d.soft_reset_pulse = 1'b0;
		// reserved bits never hold a value
		state_d.channel_config = state_q.channel_config & adc_cfg_pkg::CHANNEL_CONFIG_MASK; // R06

		if (chipset_soft_reset) begin
			// lock and port choice survive
			state_d.channel_config = adc_cfg_pkg::CHANNEL_CONFIG_RST; // R11
		end else if (cfg_write) begin
			state_d.channel_config = req.wdata & adc_cfg_pkg::CHANNEL_CONFIG_MASK; // R06
			state_d.channel_config[adc_cfg_pkg::SOFT_RESET_BIT] = 1'b0;
			state_d.soft_reset_pulse = req.wdata[adc_cfg_pkg::SOFT_RESET_BIT]; // R05
		end

		if (lock_write) begin
			if (state_q.spi_active) begin
				state_d.port_locked = 1'b1; // R10
			end else if (req.wdata[adc_cfg_pkg::PORT_LOCK_BIT]) begin
				state_d.port_locked = 1'b1;
			end
		end

		// toggles only count while unlocked and still on i2c
		if (!state_q.port_locked && !state_q.spi_active && pin_edge) begin // R09
			if (state_q.toggle_count == 2'(adc_cfg_pkg::PORT_SWITCH_TOGGLES - 1)) begin
				state_d.spi_active   = 1'b1; // R07
				state_d.toggle_count = 2'b00;
			end else begin
				state_d.toggle_count = state_q.toggle_count + 2'b01;
			end
		end

		state_d.rdata = state_q.rdata;
		if (req.rd_en) begin
			case (req.addr)
				adc_cfg_pkg::CHANNEL_CONFIG_ADDR: begin
					state_d.rdata = state_q.channel_config;
				end
				adc_cfg_pkg::PORT_LOCK_ADDR: begin
					state_d.rdata = {7'h00, state_q.port_locked}; // R06
				end
				default: begin
					state_d.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= '{
				channel_config:   adc_cfg_pkg::CHANNEL_CONFIG_RST, // R01
				port_locked:      adc_cfg_pkg::PORT_LOCK_RST[0],   // R12
				spi_active:       1'b0,                            // R12
				toggle_count:     2'b00,
				pin_sync:         2'b00,
				pin_prev:         1'b0,
				soft_reset_pulse: 1'b0,
				rdata:            8'h00
			};
			rvalid_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			rvalid_q <= req.rd_en;
		end
	end

	remote_clock_gen #(
		.HALF_PERIOD(adc_cfg_pkg::CLK_HALF_PERIOD)
	) u_clock (
		.clk                    (clk),
		.reset                  (reset),
		.disable_clock          (state_q.channel_config[adc_cfg_pkg::CLOCK_DISABLE_BIT]), // R04
		.remote_clock_output_pin(remote_clock_output_pin)
	);

	assign rdata                       = state_q.rdata;
	assign rvalid                      = rvalid_q;
	assign spi_port_active             = state_q.spi_active;
	assign port_locked                 = state_q.port_locked;
	assign phase_a_second_input_select = state_q.channel_config[adc_cfg_pkg::SELECT_LSB];     // R01
	assign phase_b_second_input_select = state_q.channel_config[adc_cfg_pkg::SELECT_LSB + 1];
	assign phase_c_second_input_select = state_q.channel_config[adc_cfg_pkg::SELECT_LSB + 2];
	assign neutral_second_input_select = state_q.channel_config[adc_cfg_pkg::SELECT_LSB + 3];
	// one means temperature sensor on the second channel
	assign temperature_route           = ~state_q.channel_config[adc_cfg_pkg::SELECT_W-1:0]; // R02
	assign remote_adc_soft_reset       = state_q.soft_reset_pulse; // R05

endmodule : adc_config_bank

`default_nettype wire

/* verif/adc_config_bank_chk.sv */
// port assertions for the config bank
// assumes bind onto adc_config_bank, one clock
`timescale 1ns/1ps
`default_nettype none
module adc_config_bank_chk (
	// system
	input wire logic                  clk,
	input wire logic                  reset,
	input wire logic                  chipset_soft_reset,
	// register access
	input wire adc_cfg_pkg::reg_req_t req,
	input wire logic [7:0]            rdata,
	input wire logic                  rvalid,
	// outputs
	input wire logic                  spi_port_active,
	input wire logic                  port_locked,
	input wire logic                  phase_a_second_input_select,
	input wire logic [3:0]            temperature_route,
	input wire logic                  remote_adc_soft_reset,
	input wire logic                  remote_clock_output_pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence cfg_wr_s;
		req.wr_en && req.addr == adc_cfg_pkg::CHANNEL_CONFIG_ADDR && !chipset_soft_reset;
	endsequence
	sequence pulse_s;
		remote_adc_soft_reset ##1 !remote_adc_soft_reset;
	endsequence
	sel_update_a: assert property (cfg_wr_s |=> phase_a_second_input_select == $past(req.wdata[0]))
		else $error("select not written");
	temp_route_a: assert property (temperature_route[0] != phase_a_second_input_select)
		else $error("route wrong");
	route_write_a: assert property (cfg_wr_s |=> temperature_route == ~$past(req.wdata[3:0]))
		else $error("route not written");
	soft_pulse_a: assert property ((cfg_wr_s ##0 req.wdata[7]) |=> pulse_s)
		else $error("no reset pulse");
	clk_hold_a: assert property ((cfg_wr_s ##0 req.wdata[6]) |-> ##3 remote_clock_output_pin)
		else $error("clock pin not high");
	rsvd_read_a: assert property (rvalid |-> rdata[5:4] == 2'h0 && !rdata[7])
		else $error("reserved bits set");
	lock_keep_a: assert property (port_locked |=> port_locked && $stable(spi_port_active))
		else $error("lock lost");
	spi_lock_a: assert property (spi_port_active && req.wr_en
		&& req.addr == adc_cfg_pkg::PORT_LOCK_ADDR |=> port_locked) else $error("no lock");
	hw_reset_a: assert property (disable iff (1'b0) reset |=> !port_locked && !spi_port_active)
		else $error("reset kept lock");
endmodule : adc_config_bank_chk
bind adc_config_bank adc_config_bank_chk adc_config_bank_chk_i (.*);
`default_nettype wire

/* verif/host_model.sv */
// host side: byte accesses and select pin toggles
// assumes one caller process at a time
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// system
	input  wire logic                 clk,
	// host side
	output var adc_cfg_pkg::reg_req_t req,
	output var logic                  pin
);
	initial begin
		req = '0;
		pin = 1'b0;
	end
	// idle bus shows inverted values
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr_en: w, rd_en: !w, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
	endtask : acc
	task automatic tog;
		repeat (16) @(posedge clk);
		pin <= !pin;
	endtask : tog
endmodule : host_model
`default_nettype wire

/* verif/adc_config_bank_tb.sv */
// self-checking bench for the config bank
// assumes host_model and the checker bind are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module adc_config_bank_tb;
	localparam logic [15:0] CFG = adc_cfg_pkg::CHANNEL_CONFIG_ADDR;
	localparam logic [15:0] LCK = adc_cfg_pkg::PORT_LOCK_ADDR;
	logic clk, reset, chipset_soft_reset, rvalid, pin, spi, locked, clk_pin;
	adc_cfg_pkg::reg_req_t req;
	logic [7:0] rdata, d;
	logic [7:0] exp_q[$];
	logic [3:0] route, sel;
	int errors;
	int n_checks;
	adc_config_bank adc_config_bank_i (.clk(clk), .reset(reset),
		.chipset_soft_reset(chipset_soft_reset), .req(req), .rdata(rdata), .rvalid(rvalid),
		.select_or_stream_active_pin(pin), .spi_port_active(spi), .port_locked(locked),
		.phase_a_second_input_select(sel[0]), .phase_b_second_input_select(sel[1]),
		.phase_c_second_input_select(sel[2]), .neutral_second_input_select(sel[3]),
		.temperature_route(route), .remote_adc_soft_reset(), .remote_clock_output_pin(clk_pin));
	host_model host_model_i (.clk(clk), .req(req), .pin(pin));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_model_i.acc(1'b0, a, 8'h00);
	endtask : rd
	task automatic rst(input logic hw);
		if (hw) reset <= 1'b1;
		else chipset_soft_reset <= 1'b1;
		repeat (hw ? 8 : 1) @(posedge clk);
		reset <= 1'b0;
		chipset_soft_reset <= 1'b0;
	endtask : rst
	task automatic tog_wait(input int n);
		repeat (n) host_model_i.tog();
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask : tog_wait
	task automatic stop_test;
		if (errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	always @(negedge clk) begin
		if (rvalid === 1'b1) chk(rdata, exp_q.pop_front());
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100us;
		errors++;
		stop_test();
	end
	initial begin
		reset = 1'b1;
		chipset_soft_reset = 1'b0;
		void'($urandom(32'h31175E98));
		rst(1'b1);
		rd(CFG, adc_cfg_pkg::CHANNEL_CONFIG_RST);
		rd(LCK, 8'h00);
		rd(16'hE709, 8'h00);
		repeat (6) begin
			d = 8'($urandom);
			host_model_i.acc(1'b1, CFG, d);
			rd(CFG, d & 8'h4F);
			chk(8'(route), {4'h0, ~d[3:0]});
			chk(8'(sel), {4'h0, d[3:0]});
		end
		host_model_i.acc(1'b1, CFG, 8'hC0);
		repeat (3) @(posedge clk);
		repeat (4) @(negedge clk) chk(8'(clk_pin), 8'h01);
		rst(1'b0);
		rd(CFG, 8'h0F);
		host_model_i.acc(1'b1, LCK, 8'h01);
		tog_wait(4);
		chk(8'(spi), 8'h00);
		host_model_i.acc(1'b1, LCK, 8'h00);
		rst(1'b0);
		rd(LCK, 8'h01);
		rst(1'b1);
		@(negedge clk);
		chk(8'(locked), 8'h00);
		host_model_i.acc(1'b1, LCK, 8'h00);
		rd(LCK, 8'h00);
		tog_wait(2);
		chk(8'(spi), 8'h00);
		tog_wait(1);
		chk(8'(spi), 8'h01);
		host_model_i.acc(1'b1, LCK, 8'h00);
		@(negedge clk);
		chk(8'(locked), 8'h01);
		rst(1'b0);
		tog_wait(3);
		chk(8'(spi), 8'h01);
		rd(LCK, 8'h01);
		rst(1'b1);
		@(negedge clk);
		chk(8'({spi, locked}), 8'h00);
		repeat (4) @(posedge clk);
		stop_test();
	end
endmodule : adc_config_bank_tb
`default_nettype wire
